// file: hdl/rcpo_defines.svh
// Register offsets, field positions and reset values of the right-channel power override bank.
// Assumes an 8-bit control port with an 8-bit register address.
`ifndef RCPO_DEFINES_SVH
`define RCPO_DEFINES_SVH

`define RCPO_OVR_A_OFFSET    8'h26
`define RCPO_OVR_B_OFFSET    8'h27
`define RCPO_STATE_A_OFFSET  8'h28
`define RCPO_STATE_B_OFFSET  8'h29
`define RCPO_REG_RESET       8'h00

// Bank A fields
`define RCPO_A_DAC           4
`define RCPO_A_LINE_DRIVER   3
`define RCPO_A_LINE_BIAS     2
`define RCPO_A_CM_FEEDBACK   1
`define RCPO_A_OUTPUT_STAGE  0
// Bank B fields
`define RCPO_B_GAIN_CTRL     7
`define RCPO_B_ANALOG_MUTE   6
`define RCPO_B_DUMMY_MUTE    5
`define RCPO_B_OFFSET_CAL    3
`define RCPO_B_SHORT_PROT    2
`define RCPO_B_IMP_SENSE     1
`define RCPO_B_IMP_WHOLE     0

`endif

// file: hdl/rcpo_pkg.sv
// Types shared by the right-channel power override bank.
// Assumes rcpo_defines.svh supplies all numeric constants.
package rcpo_pkg;
    typedef logic [7:0] rcpo_byte_type;
    // Bit order of the twelve sub-block controls on the analog side
    typedef struct packed {
        logic gainCtrl;
        logic analogMute;
        logic dummyMute;
        logic offsetCal;
        logic shortProt;
        logic impSense;
        logic impWhole;
        logic dac;
        logic lineDriver;
        logic lineBias;
        logic cmFeedback;
        logic outputStage;
    } rcpo_ctrl_type;
endpackage : rcpo_pkg

// file: hdl/rcpo_regs_if.sv
// Carrier between the register file and the override mux.
// Assumes both ends run on the same clock.
interface rcpo_regs_if;
    logic [7:0] overrideA;  // Override enables, first bank
    logic [7:0] overrideB;  // Override enables, second bank
    logic [7:0] stateA;     // Forced states, first bank
    logic [7:0] stateB;     // Forced states, second bank
    modport source (output overrideA, overrideB, stateA, stateB);
    modport sink   (input  overrideA, overrideB, stateA, stateB);
endinterface : rcpo_regs_if

// file: hdl/rcpo_reg_file.sv
// Four 8-bit read/write registers of the override bank.
// Assumes single-cycle write strobes from the control port.
`include "rcpo_defines.svh"
module rcpo_reg_file
(
    input  wire logic              clock,     // System clock
    input  wire logic              reset_n,   // Synchronous reset, active low
    input  wire logic              wrEn,      // Write strobe
    input  wire logic [7:0]        addr,      // Register address
    input  wire logic [7:0]        wrData,    // Write data
    rcpo_regs_if.source            regs       // Register contents
);
    import rcpo_pkg::*;

    rcpo_byte_type ovrA_q;
    rcpo_byte_type ovrB_q;
    rcpo_byte_type stA_q;
    rcpo_byte_type stB_q;

    // All eight bits store, reserved ones too, and clear on reset
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            ovrA_q <= `RCPO_REG_RESET;
            ovrB_q <= `RCPO_REG_RESET;
            stA_q  <= `RCPO_REG_RESET;
            stB_q  <= `RCPO_REG_RESET;
        end
        else if (wrEn)
        begin
            unique case (addr)
                `RCPO_OVR_A_OFFSET:   ovrA_q <= wrData;
                `RCPO_OVR_B_OFFSET:   ovrB_q <= wrData;
                `RCPO_STATE_A_OFFSET: stA_q  <= wrData;
                `RCPO_STATE_B_OFFSET: stB_q  <= wrData;
                default: ;
            endcase
        end
    end

    assign regs.overrideA = ovrA_q;
    assign regs.overrideB = ovrB_q;
    assign regs.stateA    = stA_q;
    assign regs.stateB    = stB_q;
endmodule : rcpo_reg_file

// file: hdl/rcpo_override_mux.sv
// Per-sub-block choice between the sequencer and the forced state.
// Assumes registered inputs; output is combinational, registered by the top.
`include "rcpo_defines.svh"
module rcpo_override_mux
(
    rcpo_regs_if.sink                    regs,     // Register contents
    input  wire rcpo_pkg::rcpo_ctrl_type autoCtrl, // Sequencer power-up levels
    output      rcpo_pkg::rcpo_ctrl_type muxCtrl   // Level to drive to analog
);
    import rcpo_pkg::*;

    rcpo_ctrl_type ovr;
    rcpo_ctrl_type st;

    // Gather enables and states into the analog bit order
    assign ovr = {regs.overrideB[`RCPO_B_GAIN_CTRL], regs.overrideB[`RCPO_B_ANALOG_MUTE],
                  regs.overrideB[`RCPO_B_DUMMY_MUTE], regs.overrideB[`RCPO_B_OFFSET_CAL],
                  regs.overrideB[`RCPO_B_SHORT_PROT], regs.overrideB[`RCPO_B_IMP_SENSE],
                  regs.overrideB[`RCPO_B_IMP_WHOLE], regs.overrideA[`RCPO_A_DAC],
                  regs.overrideA[`RCPO_A_LINE_DRIVER], regs.overrideA[`RCPO_A_LINE_BIAS],
                  regs.overrideA[`RCPO_A_CM_FEEDBACK], regs.overrideA[`RCPO_A_OUTPUT_STAGE]};
    assign st  = {regs.stateB[`RCPO_B_GAIN_CTRL], regs.stateB[`RCPO_B_ANALOG_MUTE],
                  regs.stateB[`RCPO_B_DUMMY_MUTE], regs.stateB[`RCPO_B_OFFSET_CAL],
                  regs.stateB[`RCPO_B_SHORT_PROT], regs.stateB[`RCPO_B_IMP_SENSE],
                  regs.stateB[`RCPO_B_IMP_WHOLE], regs.stateA[`RCPO_A_DAC],
                  regs.stateA[`RCPO_A_LINE_DRIVER], regs.stateA[`RCPO_A_LINE_BIAS],
                  regs.stateA[`RCPO_A_CM_FEEDBACK], regs.stateA[`RCPO_A_OUTPUT_STAGE]};

    // Enable 1 takes the forced state, 0 leaves the sequencer in charge
    genvar i;
    generate
        for (i = 0; i < 12; i++)
        begin : g_sel
            assign muxCtrl[i] = ovr[i] ? st[i] : autoCtrl[i];
        end
    endgenerate
endmodule : rcpo_override_mux

// file: hdl/rcpo_top.sv
// Right-channel analog power override bank with its control-port access.
// Assumes a synchronous byte control port: one write or read strobe per cycle.
`include "rcpo_defines.svh"
module rcpo_top
(
    input  wire logic                   clock,      // 125 MHz system clock
    input  wire logic                   reset_n,    // Synchronous reset, active low
    input  wire logic                   wrEn,       // Control-port write strobe
    input  wire logic                   rdEn,       // Control-port read strobe
    input  wire logic [7:0]             addr,       // Register address
    input  wire logic [7:0]             wrData,     // Write data
    output      logic [7:0]             rdData,     // Read data, one cycle after rdEn
    output      logic                   rdValid,    // Read data valid pulse
    input  wire rcpo_pkg::rcpo_ctrl_type autoCtrl,  // Sequencer levels, 1 = power up
    output      rcpo_pkg::rcpo_ctrl_type powerCtrl  // Levels to analog, 1 = power up
);
    import rcpo_pkg::*;

    rcpo_regs_if   regs ();
    rcpo_ctrl_type muxCtrl;
    rcpo_byte_type rdData_d;

    rcpo_reg_file u_reg_file
    (
        .clock   (clock),
        .reset_n (reset_n),
        .wrEn    (wrEn),
        .addr    (addr),
        .wrData  (wrData),
        .regs    (regs.source)
    );

    rcpo_override_mux u_mux
    (
        .regs     (regs.sink),
        .autoCtrl (autoCtrl),
        .muxCtrl  (muxCtrl)
    );

    // Read decode; unmapped addresses read zero
    always_comb
    begin
        unique case (addr)
            `RCPO_OVR_A_OFFSET:   rdData_d = regs.overrideA;
            `RCPO_OVR_B_OFFSET:   rdData_d = regs.overrideB;
            `RCPO_STATE_A_OFFSET: rdData_d = regs.stateA;
            `RCPO_STATE_B_OFFSET: rdData_d = regs.stateB;
            default:              rdData_d = 8'h00;
        endcase
    end

    // Read port registered so outputs come from flops
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            rdData  <= 8'h00;
            rdValid <= 1'b0;
        end
        else
        begin
            rdValid <= rdEn;
            if (rdEn)
                rdData <= rdData_d;
        end
    end

    // Analog controls registered: one cycle of latency avoids glitches into analog
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            powerCtrl <= '0;
        else
            powerCtrl <= muxCtrl;
    end

    // Analog mute follows forced state under override
    mute_force_a: assert property (@(posedge clock) disable iff (!reset_n)
        regs.overrideB[6] |=> powerCtrl.analogMute == $past(regs.stateB[6]))
        else $error("analog mute override not applied");
    mute_state_a: assert property (@(posedge clock) disable iff (!reset_n)
        regs.overrideB[6] && !regs.stateB[6] |=> !powerCtrl.analogMute)
        else $error("forced mute power down not seen");
    short_force_a: assert property (@(posedge clock) disable iff (!reset_n)
        regs.overrideB[2] |=> powerCtrl.shortProt == $past(regs.stateB[2]))
        else $error("short protection override not applied");
    whole_force_a: assert property (@(posedge clock) disable iff (!reset_n)
        regs.overrideB[0] |=> powerCtrl.impWhole == $past(regs.stateB[0]))
        else $error("whole sense override not applied");
    ofs_force_a: assert property (@(posedge clock) disable iff (!reset_n)
        regs.overrideB[3] |=> powerCtrl.offsetCal == $past(regs.stateB[3]))
        else $error("offset calibration override not applied");
    dac_auto_a: assert property (@(posedge clock) disable iff (!reset_n)
        !regs.overrideA[4] |=> powerCtrl.dac == $past(autoCtrl.dac))
        else $error("dac not following sequencer");
    out_force_a: assert property (@(posedge clock) disable iff (!reset_n)
        regs.overrideA[0] |=> powerCtrl.outputStage == $past(regs.stateA[0]))
        else $error("output stage override not applied");
    write_back_a: assert property (@(posedge clock) disable iff (!reset_n)
        wrEn && addr == `RCPO_OVR_A_OFFSET |=> regs.overrideA == $past(wrData))
        else $error("override bank A write lost");
    write_state_a: assert property (@(posedge clock) disable iff (!reset_n)
        wrEn && addr == `RCPO_STATE_B_OFFSET ##1 rdEn && addr == `RCPO_STATE_B_OFFSET
        |=> rdData == $past(wrData, 2))
        else $error("state bank B readback mismatch");
    reset_zero_a: assert property (@(posedge clock)
        !reset_n |=> regs.overrideA == 8'h00 && regs.stateB == 8'h00 && powerCtrl == '0)
        else $error("reset values not zero");
    gain_bit_a: assert property (@(posedge clock) disable iff (!reset_n)
        regs.overrideB[7] |=> powerCtrl.gainCtrl == $past(regs.stateB[7]))
        else $error("gain control override not applied");
    line_state_a: assert property (@(posedge clock) disable iff (!reset_n)
        regs.overrideA[3] |=> powerCtrl.lineDriver == $past(regs.stateA[3]))
        else $error("line driver override not applied");

    // Forced state reaches the remaining sub-blocks while their override is set
    dac_force_a: assert property (@(posedge clock) disable iff (!reset_n)
        regs.overrideA[`RCPO_A_DAC]
        |=> powerCtrl.dac == $past(regs.stateA[`RCPO_A_DAC]))
        else $error("dac override not applied");

    bias_force_a: assert property (@(posedge clock) disable iff (!reset_n)
        regs.overrideA[`RCPO_A_LINE_BIAS]
        |=> powerCtrl.lineBias == $past(regs.stateA[`RCPO_A_LINE_BIAS]))
        else $error("line bias override not applied");

    cmfb_force_a: assert property (@(posedge clock) disable iff (!reset_n)
        regs.overrideA[`RCPO_A_CM_FEEDBACK]
        |=> powerCtrl.cmFeedback == $past(regs.stateA[`RCPO_A_CM_FEEDBACK]))
        else $error("feedback override not applied");

    dummy_force_a: assert property (@(posedge clock) disable iff (!reset_n)
        regs.overrideB[`RCPO_B_DUMMY_MUTE]
        |=> powerCtrl.dummyMute == $past(regs.stateB[`RCPO_B_DUMMY_MUTE]))
        else $error("dummy mute override not applied");

    sense_force_a: assert property (@(posedge clock) disable iff (!reset_n)
        regs.overrideB[`RCPO_B_IMP_SENSE]
        |=> powerCtrl.impSense == $past(regs.stateB[`RCPO_B_IMP_SENSE]))
        else $error("impedance sense override not applied");

    // Clear enables on the first bank leave the sequencer in charge
    line_auto_a: assert property (@(posedge clock) disable iff (!reset_n)
        !regs.overrideA[`RCPO_A_LINE_DRIVER]
        |=> powerCtrl.lineDriver == $past(autoCtrl.lineDriver))
        else $error("line driver not following sequencer");

    bias_auto_a: assert property (@(posedge clock) disable iff (!reset_n)
        !regs.overrideA[`RCPO_A_LINE_BIAS]
        |=> powerCtrl.lineBias == $past(autoCtrl.lineBias))
        else $error("line bias not following sequencer");

    cmfb_auto_a: assert property (@(posedge clock) disable iff (!reset_n)
        !regs.overrideA[`RCPO_A_CM_FEEDBACK]
        |=> powerCtrl.cmFeedback == $past(autoCtrl.cmFeedback))
        else $error("feedback not following sequencer");

    out_auto_a: assert property (@(posedge clock) disable iff (!reset_n)
        !regs.overrideA[`RCPO_A_OUTPUT_STAGE]
        |=> powerCtrl.outputStage == $past(autoCtrl.outputStage))
        else $error("output stage not following sequencer");

    // Clear enables on the second bank leave the sequencer in charge
    gain_auto_a: assert property (@(posedge clock) disable iff (!reset_n)
        !regs.overrideB[`RCPO_B_GAIN_CTRL]
        |=> powerCtrl.gainCtrl == $past(autoCtrl.gainCtrl))
        else $error("gain control not following sequencer");

    mute_auto_a: assert property (@(posedge clock) disable iff (!reset_n)
        !regs.overrideB[`RCPO_B_ANALOG_MUTE]
        |=> powerCtrl.analogMute == $past(autoCtrl.analogMute))
        else $error("analog mute not following sequencer");

    dummy_auto_a: assert property (@(posedge clock) disable iff (!reset_n)
        !regs.overrideB[`RCPO_B_DUMMY_MUTE]
        |=> powerCtrl.dummyMute == $past(autoCtrl.dummyMute))
        else $error("dummy mute not following sequencer");

    ofs_auto_a: assert property (@(posedge clock) disable iff (!reset_n)
        !regs.overrideB[`RCPO_B_OFFSET_CAL]
        |=> powerCtrl.offsetCal == $past(autoCtrl.offsetCal))
        else $error("offset calibration not following sequencer");

    short_auto_a: assert property (@(posedge clock) disable iff (!reset_n)
        !regs.overrideB[`RCPO_B_SHORT_PROT]
        |=> powerCtrl.shortProt == $past(autoCtrl.shortProt))
        else $error("short protection not following sequencer");

    sense_auto_a: assert property (@(posedge clock) disable iff (!reset_n)
        !regs.overrideB[`RCPO_B_IMP_SENSE]
        |=> powerCtrl.impSense == $past(autoCtrl.impSense))
        else $error("impedance sense not following sequencer");

    whole_auto_a: assert property (@(posedge clock) disable iff (!reset_n)
        !regs.overrideB[`RCPO_B_IMP_WHOLE]
        |=> powerCtrl.impWhole == $past(autoCtrl.impWhole))
        else $error("whole sense not following sequencer");

    // Each mapped write lands whole, reserved bits too; nothing else moves a register
    write_ovrb_a: assert property (@(posedge clock) disable iff (!reset_n)
        wrEn && addr == `RCPO_OVR_B_OFFSET
        |=> regs.overrideB == $past(wrData))
        else $error("override bank B write lost");

    write_sta_a: assert property (@(posedge clock) disable iff (!reset_n)
        wrEn && addr == `RCPO_STATE_A_OFFSET
        |=> regs.stateA == $past(wrData))
        else $error("state bank A write lost");

    write_stb_a: assert property (@(posedge clock) disable iff (!reset_n)
        wrEn && addr == `RCPO_STATE_B_OFFSET
        |=> regs.stateB == $past(wrData))
        else $error("state bank B write lost");

    write_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
        !wrEn
        |=> $stable({regs.overrideA, regs.overrideB, regs.stateA, regs.stateB}))
        else $error("register changed without a write");

    write_unmapped_a: assert property (@(posedge clock) disable iff (!reset_n)
        wrEn && !(addr inside {[`RCPO_OVR_A_OFFSET:`RCPO_STATE_B_OFFSET]})
        |=> $stable({regs.overrideA, regs.overrideB, regs.stateA, regs.stateB}))
        else $error("unmapped write changed a register");

    // A read straight after a write returns the new value
    ovra_readback_a: assert property (@(posedge clock) disable iff (!reset_n)
        wrEn && addr == `RCPO_OVR_A_OFFSET ##1 rdEn && addr == `RCPO_OVR_A_OFFSET
        |=> rdData == $past(wrData, 2))
        else $error("override bank A readback mismatch");

    ovrb_readback_a: assert property (@(posedge clock) disable iff (!reset_n)
        wrEn && addr == `RCPO_OVR_B_OFFSET ##1 rdEn && addr == `RCPO_OVR_B_OFFSET
        |=> rdData == $past(wrData, 2))
        else $error("override bank B readback mismatch");

    sta_readback_a: assert property (@(posedge clock) disable iff (!reset_n)
        wrEn && addr == `RCPO_STATE_A_OFFSET ##1 rdEn && addr == `RCPO_STATE_A_OFFSET
        |=> rdData == $past(wrData, 2))
        else $error("state bank A readback mismatch");

    // Read strobe answered by a one-cycle valid; data holds between reads
    read_valid_a: assert property (@(posedge clock) disable iff (!reset_n)
        rdEn
        |=> rdValid)
        else $error("read strobe not answered");

    read_pulse_a: assert property (@(posedge clock) disable iff (!reset_n)
        !rdEn
        |=> !rdValid)
        else $error("read valid without a strobe");

    read_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
        !rdEn
        |=> $stable(rdData))
        else $error("read data moved without a read");

    // Reads return the addressed register as it stood before the edge
    read_ovra_a: assert property (@(posedge clock) disable iff (!reset_n)
        rdEn && addr == `RCPO_OVR_A_OFFSET
        |=> rdData == $past(regs.overrideA))
        else $error("override bank A read wrong");

    read_ovrb_a: assert property (@(posedge clock) disable iff (!reset_n)
        rdEn && addr == `RCPO_OVR_B_OFFSET
        |=> rdData == $past(regs.overrideB))
        else $error("override bank B read wrong");

    read_sta_a: assert property (@(posedge clock) disable iff (!reset_n)
        rdEn && addr == `RCPO_STATE_A_OFFSET
        |=> rdData == $past(regs.stateA))
        else $error("state bank A read wrong");

    read_stb_a: assert property (@(posedge clock) disable iff (!reset_n)
        rdEn && addr == `RCPO_STATE_B_OFFSET
        |=> rdData == $past(regs.stateB))
        else $error("state bank B read wrong");

    read_unmapped_a: assert property (@(posedge clock) disable iff (!reset_n)
        rdEn && !(addr inside {[`RCPO_OVR_A_OFFSET:`RCPO_STATE_B_OFFSET]})
        |=> rdData == 8'h00)
        else $error("unmapped read not zero");

    // Reset clears the rest of the bank and the read port; release hands back to the sequencer
    reset_rest_a: assert property (@(posedge clock)
        !reset_n
        |=> regs.overrideB == `RCPO_REG_RESET && regs.stateA == `RCPO_REG_RESET && !rdValid)
        else $error("bank or read port not cleared by reset");

    reset_auto_a: assert property (@(posedge clock)
        !reset_n ##1 reset_n
        |=> powerCtrl == $past(autoCtrl) && rdData == 8'h00)
        else $error("sequencer not in charge after reset");
endmodule : rcpo_top

// file: tb/tb_top.sv
// Self-checking bench for the right-channel power override bank.
// Assumes rcpo_top with its byte strobe port; drives every input itself.
module tb_top import rcpo_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic          clock;     // System clock
    logic          reset_n;   // Synchronous reset, active low
    logic          wrEn;      // Write strobe
    logic          rdEn;      // Read strobe
    logic [7:0]    addr;      // Register address
    logic [7:0]    wrData;    // Write data
    logic [7:0]    rdData;    // Read data
    logic          rdValid;   // Read data valid
    rcpo_ctrl_type autoCtrl;  // Sequencer levels
    rcpo_ctrl_type powerCtrl; // Levels to analog
    logic [7:0]    regModel [4];
    logic [7:0]    expRd;
    logic [11:0]   expPwr;
    logic          expValid;
    logic          armed;
    logic [31:0]   seed;
    int            errCount;
    int            checks;

    rcpo_top u_dut (.clock(clock), .reset_n(reset_n), .wrEn(wrEn), .rdEn(rdEn), .addr(addr),
        .wrData(wrData), .rdData(rdData), .rdValid(rdValid), .autoCtrl(autoCtrl),
        .powerCtrl(powerCtrl));

    // Clock at 125 MHz
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Xorshift source, fixed start so every run repeats
    function logic [31:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : next_rand

    // Expected analog levels: forced state where overridden, sequencer elsewhere
    function logic [11:0] exp_power();
        logic [11:0] ovr;
        logic [11:0] st;
        ovr = {regModel[1][7:5], regModel[1][3:0], regModel[0][4:0]};
        st  = {regModel[3][7:5], regModel[3][3:0], regModel[2][4:0]};
        return (ovr & st) | (~ovr & 12'(autoCtrl));
    endfunction : exp_power

    task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
        checks++;
        if (got !== exp)
        begin
            errCount++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task give_verdict();
        $display("Comparisons %0d, mismatches %0d", checks, errCount);
        if (errCount == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    // One clock of stimulus; the model advances on the same edge as the design
    task automatic step(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        logic [31:0] rv;
        logic        hit;
        rv = next_rand();
        wrEn     <= w;
        rdEn     <= r;
        addr     <= a;
        wrData   <= d;
        autoCtrl <= rcpo_ctrl_type'(rv[11:0]);
        @(posedge clock);
        hit = a inside {[8'h26:8'h29]};
        if (!reset_n)
        begin
            regModel = '{default: 8'h00};
            expValid = 1'b0;
            expRd    = 8'h00;
            expPwr   = 12'h000;
        end
        else
        begin
            expValid = r;
            if (r)
                expRd = hit ? regModel[2'(a - 8'h26)] : 8'h00;
            expPwr = exp_power();
            if (w && hit)
                regModel[2'(a - 8'h26)] = d;
        end
        armed = 1'b1;
    endtask : step

    // Outputs are compared mid-cycle, once every edge has settled
    always @(negedge clock)
    begin
        if (armed)
        begin
            chk("rdValid", 12'(expValid), 12'(rdValid));
            chk("rdData", {4'h0, expRd}, {4'h0, rdData});
            chk("powerCtrl", expPwr, powerCtrl);
        end
    end

    // Hang guard
    initial
    begin
        #100000;
        errCount++;
        $display("[FAIL] watchdog expected finish seen timeout");
        give_verdict();
    end

    // Main sequence
    initial
    begin
        logic [31:0] r;
        seed = 32'hC2C3;
        errCount = 0;
        checks = 0;
        armed = 1'b0;
        reset_n = 1'b0;
        wrEn = 1'b0;
        rdEn = 1'b0;
        addr = 8'h00;
        wrData = 8'h00;
        autoCtrl = '0;
        repeat (12) step(1'b0, 1'b0, 8'h26, 8'hFF);
        reset_n <= 1'b1;
        for (int i = 0; i < 4; i++) step(1'b0, 1'b1, 8'h26 + 8'(i), 8'h00);
        // Every bit of every register, reserved ones included, written then read back
        for (int i = 0; i < 32; i++)
        begin
            step(1'b1, 1'b0, 8'h26 + 8'(i / 8), 8'h01 << (i % 8));
            step(1'b0, 1'b1, 8'h26 + 8'(i / 8), 8'h00);
        end
        // Random traffic over mapped and unmapped addresses, back to back
        for (int i = 0; i < 300; i++)
        begin
            r = next_rand();
            step(r[1:0] == 2'h1, r[1:0] == 2'h2, 8'h24 + 8'(r[4:2]), r[15:8]);
        end
        // Second reset in mid-run clears everything again
        step(1'b1, 1'b0, 8'h27, 8'hFF);
        reset_n <= 1'b0;
        step(1'b1, 1'b0, 8'h29, 8'hFF);
        reset_n <= 1'b1;
        for (int i = 0; i < 4; i++) step(1'b0, 1'b1, 8'h26 + 8'(i), 8'h00);
        step(1'b0, 1'b0, 8'h00, 8'h00);
        give_verdict();
    end
endmodule : tb_top
